// *** hdl/fpr_pkg.sv ***
/*
 * shared constants for the flash protect and resume control link:
 * opcodes, status bit positions, timing counts, host serial timing.
 * assumes a 100 MHz reference clock on both ends.
 */
package fpr_pkg;

	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int REF_MHZ            = 100;
	localparam int RESUME_TIME_NS     = 2000;
	localparam int PROT_ASSERT_NS     = 1000;
	localparam int PROT_RELEASE_NS    = 1000;
	localparam int TMR_W              = 16;
	localparam logic [TMR_W-1:0] RESUME_CYC  = TMR_W'(RESUME_TIME_NS * REF_MHZ / 1000);
	localparam logic [TMR_W-1:0] ASSERT_CYC  = TMR_W'(PROT_ASSERT_NS * REF_MHZ / 1000);
	localparam logic [TMR_W-1:0] RELEASE_CYC = TMR_W'(PROT_RELEASE_NS * REF_MHZ / 1000);
	localparam logic [2:0] SCK_HALF   = 3'h3;
	localparam logic [2:0] CS_GAP     = 3'h7;

	// ------------------------------------------------------------
	// opcodes
	// ------------------------------------------------------------
	localparam logic [7:0] OPC_RESUME     = 8'hD0;
	localparam logic [7:0] OPC_PROT_B0    = 8'h3D;
	localparam logic [7:0] OPC_PROT_B1    = 8'h2A;
	localparam logic [7:0] OPC_PROT_B2    = 8'h7F;
	localparam logic [7:0] OPC_PROT_EN    = 8'hA9;
	localparam logic [7:0] OPC_PROT_DIS   = 8'h9A;
	localparam logic [7:0] OPC_SUSPEND    = 8'h01;
	localparam logic [7:0] OPC_STATUS     = 8'h02;
	localparam logic [7:0] OPC_LOCKDOWN   = 8'h03;
	localparam logic [7:0] OPC_FREEZE     = 8'h04;
	localparam logic [7:0] OPC_SEC_PROG   = 8'h06;
	localparam logic [7:0] OPC_DPD_ENTER  = 8'h07;
	localparam logic [7:0] OPC_DPD_EXIT   = 8'h08;
	localparam logic [7:0] OPC_UDPD_ENTER = 8'h09;
	localparam logic [7:0] OPC_XFER_B1    = 8'h0A;
	localparam logic [7:0] OPC_XFER_B2    = 8'h0B;
	localparam logic [7:0] OPC_CMP_B1     = 8'h0C;
	localparam logic [7:0] OPC_CMP_B2     = 8'h0D;

	// ------------------------------------------------------------
	// status byte
	// ------------------------------------------------------------
	localparam int ST_RDY  = 7;
	localparam int ST_PROT = 6;
	localparam int ST_ES   = 2;
	localparam int ST_PS2  = 1;
	localparam int ST_PS1  = 0;

	localparam logic [1:0] SEL_PS1 = 2'h0;
	localparam logic [1:0] SEL_PS2 = 2'h1;
	localparam logic [1:0] SEL_ES  = 2'h2;

	typedef enum logic [2:0] {
		FPR_IDLE  = 3'b000,
		FPR_SETUP = 3'b001,
		FPR_SHIFT = 3'b010,
		FPR_HOLD  = 3'b011,
		FPR_GAP   = 3'b100
	} fpr_hst_e;

endpackage

// *** hdl/fpr_if.sv ***
/*
 * serial link between flash control end and host end.
 * assumes data out has a pull-up when not driven.
 */
`timescale 1ns/1ps
interface fpr_if;
	logic sck;
	logic csN;
	logic mosi;
	logic miso;
	logic misoOe;
	logic misoWire;
	logic wpN;

	// resolved data-out wire, pulled high when released
	assign misoWire = misoOe ? miso : 1'b1;

	modport dev (input sck, input csN, input mosi, input wpN, output miso, output misoOe);
	modport host (output sck, output csN, output mosi, output wpN, input misoWire);
endinterface

// *** hdl/fpr_dev.sv ***
/*
 * flash end: frame capture on the serial clock, command gating,
 * resume sequencing and sector protection state on ref_clk.
 * assumes the array engine reports suspends and completion.
 */
// Operation
// - suspend refuses lockdown, freeze, security, power-down
// - suspend still accepts reads, ids, resets
// - transfer refused into buffer holding suspended program
// - buffer compares always accepted during suspend
// - resume is one opcode, extra bytes ignored
// - resume: flag clears, busy after resume time
// - program resumes before erase; erase needs second
// - suspend ignored while resume still in progress
// - host waits or polls before suspending again
// - four-byte enable sequence acts at frame end
// - four-byte disable sequence acts at frame end
// - software protection cleared at power-up
// - pin low locks flagged sectors and register
// - pin only adds protection, never removes it
// - pin asserts/releases protection after filter delays
// - enable during pin low persists after release
// - disable discarded while pin asserted
// - pin input filtered against short glitches
// - status byte reports protection state
// - separate suspend flags, may be set together
`timescale 1ns/1ps
module fpr_dev
	import fpr_pkg::*;
(
	input  wire logic       ref_clk,       // core clock
	input  wire logic       rst,           // async reset, high
	fpr_if.dev              link,          // serial link
	input  wire logic       buf1SuspSet,   // program suspended, buffer one
	input  wire logic       buf2SuspSet,   // program suspended, buffer two
	input  wire logic       eraseSuspSet,  // erase suspended
	input  wire logic       opDone,        // running operation finished
	output logic            cmdValid,      // frame decoded
	output logic [7:0]      cmdOp,         // its opcode
	output logic            cmdAllowed,    // accepted under suspend state
	output logic            suspendReq,    // suspend to array engine
	output logic            resumeProg,    // restart suspended program
	output logic            resumeErase,   // restart suspended erase
	output logic            protectOn,     // sector protection active
	output logic            protRegLocked, // protection register read-only
	output logic            busy           // operation running
);

	// ------------------------------------------------------------
	// serial clock domain
	// ------------------------------------------------------------
	typedef struct packed {
		logic [2:0] bitCnt;
		logic [2:0] byteCnt;
		logic [7:0] sh;
		logic [7:0] outSh;
		logic       outEn;
	} fpr_frame_s;

	typedef struct packed {
		logic        seq;
		logic [31:0] bytes;
		logic [2:0]  byteCnt;
		logic [2:0]  bitCnt;
	} fpr_hold_s;

	typedef struct packed {
		logic             csS1;
		logic             csS2;
		logic             csS3;
		logic             wpS1;
		logic             wpS2;
		logic             wpAct;
		logic [TMR_W-1:0] wpCnt;
		logic             seenSeq;
		logic             ps1;
		logic             ps2;
		logic             es;
		logic             resuming;
		logic [1:0]       resSel;
		logic [TMR_W-1:0] resCnt;
		logic             bsy;
		logic             swEn;
		logic [7:0]       statSnap;
		logic             cmdValid;
		logic [7:0]       cmdOp;
		logic             cmdAllowed;
		logic             suspendReq;
		logic             resumeProg;
		logic             resumeErase;
		logic             protectOn;
		logic             protRegLocked;
	} fpr_core_s;

	fpr_frame_s f_q;
	fpr_frame_s f_d;
	fpr_hold_s  h_q;
	fpr_hold_s  h_d;
	fpr_core_s  r_q;
	fpr_core_s  r_d;
	logic       frameRst;
	logic [7:0] newByte;

	assign frameRst = rst | link.csN;
	assign newByte  = {f_q.sh[6:0], link.mosi};

	always_comb
	begin
		f_d = f_q;
		h_d = h_q;
		f_d.sh = newByte;
		f_d.bitCnt = f_q.bitCnt + 3'h1;
		f_d.outSh = {f_q.outSh[6:0], 1'b0};
		if (f_q.bitCnt == 3'h0 && f_q.byteCnt == 3'h0)
		begin
			h_d.seq = ~h_q.seq;
		end
		if (f_q.bitCnt == 3'h7)
		begin
			if (f_q.byteCnt != 3'h7)
			begin
				f_d.byteCnt = f_q.byteCnt + 3'h1;
			end
			for (int i = 0; i < 4; i++)
			begin
				if (f_q.byteCnt == 3'(i))
				begin
					h_d.bytes[8*(3-i) +: 8] = newByte;
				end
			end
			// status streams out repeatedly after its opcode
			if ((f_q.byteCnt == 3'h0 && newByte == OPC_STATUS) || f_q.outEn)
			begin
				f_d.outSh = r_q.statSnap;
				f_d.outEn = 1'b1;
			end
		end
		h_d.byteCnt = f_d.byteCnt;
		h_d.bitCnt = f_d.bitCnt;
	end

	// frame state clears while chip select is high
	always_ff @(posedge link.sck or posedge frameRst)
	begin
		if (frameRst)
			f_q <= '0;
		else
			f_q <= f_d;
	end

	// held across the frame end for the core to read
	always_ff @(posedge link.sck or posedge rst)
	begin
		if (rst)
			h_q <= '0;
		else
			h_q <= h_d;
	end

	assign link.miso   = f_q.outSh[7];
	assign link.misoOe = f_q.outEn;

	// ------------------------------------------------------------
	// command gating under suspend
	// ------------------------------------------------------------
	function automatic logic cmdOk(input logic [7:0] op, input logic p1,
		input logic p2, input logic e);
		logic susp;
		susp = p1 | p2 | e;
		case (op)
			OPC_LOCKDOWN, OPC_FREEZE, OPC_SEC_PROG: cmdOk = !susp;
			OPC_DPD_ENTER, OPC_DPD_EXIT, OPC_UDPD_ENTER: cmdOk = !susp;
			OPC_PROT_B0: cmdOk = !susp;
			OPC_XFER_B1: cmdOk = !p1;
			OPC_XFER_B2: cmdOk = !p2;
			OPC_CMP_B1, OPC_CMP_B2: cmdOk = 1'b1;
			default: cmdOk = 1'b1;
		endcase
	endfunction

	// ------------------------------------------------------------
	// core
	// ------------------------------------------------------------
	logic [7:0] op;
	logic       frameEnd;
	logic       protSeq;

	assign op       = h_q.bytes[31:24];
	assign frameEnd = r_q.csS2 && !r_q.csS3 && h_q.seq != r_q.seenSeq;
	assign protSeq  = h_q.byteCnt == 3'h4 && h_q.bitCnt == 3'h0
		&& h_q.bytes[31:8] == {OPC_PROT_B0, OPC_PROT_B1, OPC_PROT_B2};

	always_comb
	begin
		r_d = r_q;
		r_d.cmdValid = 1'b0;
		r_d.suspendReq = 1'b0;
		r_d.resumeProg = 1'b0;
		r_d.resumeErase = 1'b0;
		r_d.csS1 = link.csN;
		r_d.csS2 = r_q.csS1;
		r_d.csS3 = r_q.csS2;
		r_d.wpS1 = link.wpN;
		r_d.wpS2 = r_q.wpS1;

		// pin must hold its new level for the whole delay
		if (!r_q.wpS2 == r_q.wpAct)
		begin
			r_d.wpCnt = '0;
		end
		else if (r_q.wpCnt + 1'b1 >= (r_q.wpAct ? RELEASE_CYC : ASSERT_CYC))
		begin
			r_d.wpAct = !r_q.wpAct;
			r_d.wpCnt = '0;
		end
		else
		begin
			r_d.wpCnt = r_q.wpCnt + 1'b1;
		end

		// completion clears first so a resume in the same cycle wins
		if (opDone)
			r_d.bsy = 1'b0;
		if (r_q.resuming)
		begin
			r_d.resCnt = r_q.resCnt - 1'b1;
			if (r_q.resCnt == 1)
			begin
				r_d.resuming = 1'b0;
				r_d.bsy = 1'b1;
				if (r_q.resSel == SEL_PS1)
					r_d.ps1 = 1'b0;
				else if (r_q.resSel == SEL_PS2)
					r_d.ps2 = 1'b0;
				else
					r_d.es = 1'b0;
				r_d.resumeProg = r_q.resSel != SEL_ES;
				r_d.resumeErase = r_q.resSel == SEL_ES;
			end
		end

		if (frameEnd && h_q.byteCnt != 3'h0)
		begin
			r_d.seenSeq = h_q.seq;
			r_d.cmdValid = 1'b1;
			r_d.cmdOp = op;
			r_d.cmdAllowed = cmdOk(op, r_q.ps1, r_q.ps2, r_q.es);
			// trailing bytes after the resume opcode are ignored
			if (op == OPC_RESUME && !r_q.resuming && (r_q.ps1 | r_q.ps2 | r_q.es))
			begin
				r_d.resuming = 1'b1;
				r_d.resCnt = RESUME_CYC;
				if (r_q.ps1)
					r_d.resSel = SEL_PS1;
				else if (r_q.ps2)
					r_d.resSel = SEL_PS2;
				else
					r_d.resSel = SEL_ES;
			end
			if (op == OPC_SUSPEND && r_q.bsy && !r_q.resuming)
			begin
				r_d.suspendReq = 1'b1;
			end
			if (protSeq && r_d.cmdAllowed)
			begin
				if (h_q.bytes[7:0] == OPC_PROT_EN)
					r_d.swEn = 1'b1;
				else if (h_q.bytes[7:0] == OPC_PROT_DIS && !r_q.wpAct)
					r_d.swEn = 1'b0;
			end
		end
		else if (frameEnd)
		begin
			r_d.seenSeq = h_q.seq;
		end

		// engine events last so a set beats a clear
		if (buf1SuspSet)
			r_d.ps1 = 1'b1;
		if (buf2SuspSet)
			r_d.ps2 = 1'b1;
		if (eraseSuspSet)
			r_d.es = 1'b1;
		if (buf1SuspSet | buf2SuspSet | eraseSuspSet)
			r_d.bsy = 1'b0;

		// pin adds to the software enable, never clears it
		r_d.protectOn = r_q.swEn | r_q.wpAct;
		r_d.protRegLocked = r_q.wpAct;
		// snapshot frozen while a frame is open
		if (r_q.csS2)
		begin
			r_d.statSnap = '0;
			r_d.statSnap[ST_RDY] = !(r_q.bsy | r_q.resuming);
			r_d.statSnap[ST_PROT] = r_q.swEn | r_q.wpAct;
			r_d.statSnap[ST_ES] = r_q.es;
			r_d.statSnap[ST_PS2] = r_q.ps2;
			r_d.statSnap[ST_PS1] = r_q.ps1;
		end
	end

	// reset clears the software enable: power-up default off
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			r_q <= '0;
			r_q.csS1 <= 1'b1;
			r_q.csS2 <= 1'b1;
			r_q.csS3 <= 1'b1;
			r_q.wpS1 <= 1'b1;
			r_q.wpS2 <= 1'b1;
		end
		else
		begin
			r_q <= r_d;
		end
	end

	assign cmdValid      = r_q.cmdValid;
	assign cmdOp         = r_q.cmdOp;
	assign cmdAllowed    = r_q.cmdAllowed;
	assign suspendReq    = r_q.suspendReq;
	assign resumeProg    = r_q.resumeProg;
	assign resumeErase   = r_q.resumeErase;
	assign protectOn     = r_q.protectOn;
	assign protRegLocked = r_q.protRegLocked;
	assign busy          = r_q.bsy;

endmodule

// *** hdl/fpr_host.sv ***
/*
 * host end: sends one frame of whole bytes, optionally reads one
 * byte back, drives the write-protect pin.
 * assumes ref_clk at 100 MHz; serial clock derived by division.
 */
`timescale 1ns/1ps
module fpr_host
	import fpr_pkg::*;
(
	input  wire logic        ref_clk,   // core clock
	input  wire logic        rst,       // async reset, high
	fpr_if.host              link,      // serial link
	input  wire logic        req,       // start a frame
	input  wire logic [2:0]  txLen,     // bytes to send, 1 to 4
	input  wire logic [31:0] txWord,    // first byte in bits 31:24
	input  wire logic        rxEn,      // read one byte after them
	input  wire logic        wpAssert,  // hold write-protect pin low
	output logic             busy,      // frame in progress
	output logic             done,      // frame finished
	output logic [7:0]       rxByte     // byte read back
);

	typedef struct packed {
		fpr_hst_e    st;
		logic [2:0]  cnt;
		logic [5:0]  bitIdx;
		logic [5:0]  nBits;
		logic [5:0]  firstRx;
		logic [31:0] tx;
		logic [7:0]  rx;
		logic        sck;
		logic        csN;
		logic        mosi;
		logic        wpN;
		logic        mS1;
		logic        mS2;
		logic        busy;
		logic        done;
		logic [7:0]  rxByte;
	} fpr_host_s;

	fpr_host_s s_q;
	fpr_host_s s_d;

	always_comb
	begin
		s_d = s_q;
		s_d.done = 1'b0;
		s_d.mS1 = link.misoWire;
		s_d.mS2 = s_q.mS1;
		s_d.wpN = !wpAssert;
		s_d.cnt = s_q.cnt + 3'h1;
		case (s_q.st)
			FPR_IDLE:
			begin
				s_d.cnt = '0;
				if (req)
				begin
					// whole bytes only, so chip select rises aligned
					s_d.nBits = {txLen, 3'h0} + (rxEn ? 6'h08 : 6'h00);
					s_d.firstRx = {txLen, 3'h0} - 6'h01;
					s_d.tx = txWord;
					s_d.mosi = txWord[31];
					s_d.bitIdx = '0;
					s_d.csN = 1'b0;
					s_d.busy = 1'b1;
					s_d.st = FPR_SETUP;
				end
			end
			FPR_SETUP:
			begin
				if (s_q.cnt == SCK_HALF)
				begin
					s_d.cnt = '0;
					s_d.sck = 1'b1;
					s_d.st = FPR_SHIFT;
				end
			end
			FPR_SHIFT:
			begin
				if (s_q.cnt == SCK_HALF)
				begin
					s_d.cnt = '0;
					if (s_q.sck)
					begin
						s_d.sck = 1'b0;
						if (s_q.bitIdx >= s_q.firstRx && s_q.bitIdx + 6'h01 < s_q.nBits)
							s_d.rx = {s_q.rx[6:0], s_q.mS2};
						s_d.tx = {s_q.tx[30:0], 1'b0};
						s_d.mosi = s_q.tx[30];
						s_d.bitIdx = s_q.bitIdx + 6'h01;
						if (s_q.bitIdx + 6'h01 == s_q.nBits)
							s_d.st = FPR_HOLD;
					end
					else
					begin
						s_d.sck = 1'b1;
					end
				end
			end
			FPR_HOLD:
			begin
				if (s_q.cnt == SCK_HALF)
				begin
					s_d.cnt = '0;
					s_d.csN = 1'b1;
					s_d.done = 1'b1;
					s_d.rxByte = s_q.rx;
					s_d.st = FPR_GAP;
				end
			end
			FPR_GAP:
			begin
				// lets the far end see chip select high first
				if (s_q.cnt == CS_GAP)
				begin
					s_d.busy = 1'b0;
					s_d.st = FPR_IDLE;
				end
			end
			default:
			begin
				s_d.st = FPR_IDLE;
			end
		endcase
	end

	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			s_q <= '0;
			s_q.csN <= 1'b1;
			s_q.wpN <= 1'b1;
			s_q.mS1 <= 1'b1;
			s_q.mS2 <= 1'b1;
		end
		else
		begin
			s_q <= s_d;
		end
	end

	assign link.sck  = s_q.sck;
	assign link.csN  = s_q.csN;
	assign link.mosi = s_q.mosi;
	assign link.wpN  = s_q.wpN;
	assign busy      = s_q.busy;
	assign done      = s_q.done;
	assign rxByte    = s_q.rxByte;

endmodule

// *** tb/fpr_chk_sva.sv ***
/*
 * checker for the link between host end and flash end, with the main
 * device outputs. assumes the bench instantiates it beside the link.
 */
`timescale 1ns/1ps
module fpr_chk
	import fpr_pkg::*;
(
	input wire logic ref_clk,       // core clock
	input wire logic rst,           // async reset, high
	input wire logic csN,           // chip select, low active
	input wire logic wpN,           // write-protect pin, low active
	input wire logic cmdValid,      // frame decoded
	input wire logic resumeProg,    // program restarted
	input wire logic resumeErase,   // erase restarted
	input wire logic protectOn,     // protection active
	input wire logic protRegLocked, // filtered pin active
	input wire logic busy           // operation running
);
	// ------------------------------------------------
	// pin level run counters
	// ------------------------------------------------
	typedef struct packed {
		logic [TMR_W-1:0] lowCnt;
		logic [TMR_W-1:0] highCnt;
	} fpr_chk_s;

	fpr_chk_s st_q;
	fpr_chk_s st_d;

	always_comb
	begin
		st_d = st_q;
		st_d.lowCnt = wpN ? '0 : st_q.lowCnt + TMR_W'(!(&st_q.lowCnt));
		st_d.highCnt = !wpN ? '0 : st_q.highCnt + TMR_W'(!(&st_q.highCnt));
	end

	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			st_q <= '0;
		else
			st_q <= st_d;
	end

	// ------------------------------------------------
	// properties
	// ------------------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	lock_adds_prot_a: assert property (protRegLocked [*2] |-> protectOn)
		else $error("pin lock without protection");
	disable_discard_a: assert property ($fell(protectOn) |-> !protRegLocked)
		else $error("protection dropped while pin active");
	filter_assert_a: assert property ($rose(protRegLocked) |-> st_q.lowCnt >= ASSERT_CYC)
		else $error("short low pulse locked");
	filter_release_a: assert property ($fell(protRegLocked) |-> st_q.highCnt >= RELEASE_CYC)
		else $error("short high pulse released");
	assert_bound_a: assert property (st_q.lowCnt == ASSERT_CYC + 16'h0008 |-> protRegLocked)
		else $error("pin low did not lock in time");
	release_bound_a: assert property (st_q.highCnt == RELEASE_CYC + 16'h0008 |-> !protRegLocked)
		else $error("pin high did not release in time");
	frame_end_a: assert property ($rose(csN) |-> ##[2:5] cmdValid)
		else $error("frame end not decoded");
	resume_busy_a: assert property (resumeProg || resumeErase |-> ##[0:1] busy)
		else $error("resume without busy");
	resume_single_a: assert property (!(resumeProg && resumeErase))
		else $error("program and erase resumed together");

	cover property (resumeProg);
	cover property (resumeErase);
	cover property ($rose(protRegLocked));
	cover property ($fell(protectOn));
endmodule

// *** tb/tb.sv ***
/*
 * self-checking bench: host end drives flash end over the link.
 * assumes 100 MHz ref_clk and the package timing counts.
 */
`timescale 1ns/1ps
module tb
	import fpr_pkg::*;
();
	logic        ref_clk = 1'h0;
	logic        rst = 1'h0;
	logic        req = 1'h0;
	logic        rxEn = 1'h0;
	logic        wpAssert = 1'h0;
	logic [2:0]  txLen = 3'h1;
	logic [31:0] txWord = 32'h0000_0000;
	logic        b1Set = 1'h0;
	logic        b2Set = 1'h0;
	logic        eSet = 1'h0;
	logic        opDone = 1'h0;
	logic        hBusy, hDone, dBusy, cmdValid, cmdAllowed, suspendReq;
	logic        resumeProg, resumeErase, protectOn, protRegLocked;
	logic [7:0]  rxByte, cmdOp;
	int          errTotal = 0, samplesChecked = 0, nSusp = 0, nRp = 0, nRe = 0;
	int          ps1 = 0, ps2 = 0, es = 0, swEn = 0, pinAct = 0, mBusy = 0;
	logic [7:0]  ops [11] = '{OPC_LOCKDOWN, OPC_FREEZE, OPC_SEC_PROG, OPC_DPD_ENTER,
		OPC_DPD_EXIT, OPC_UDPD_ENTER, OPC_STATUS, OPC_XFER_B1, OPC_XFER_B2, OPC_CMP_B1,
		OPC_CMP_B2};

	fpr_if fpr_if_i ();
	fpr_dev fpr_dev_i (.ref_clk(ref_clk), .rst(rst), .link(fpr_if_i), .buf1SuspSet(b1Set),
		.buf2SuspSet(b2Set), .eraseSuspSet(eSet), .opDone(opDone), .cmdValid(cmdValid),
		.cmdOp(cmdOp), .cmdAllowed(cmdAllowed), .suspendReq(suspendReq),
		.resumeProg(resumeProg), .resumeErase(resumeErase), .protectOn(protectOn),
		.protRegLocked(protRegLocked), .busy(dBusy));
	fpr_host fpr_host_i (.ref_clk(ref_clk), .rst(rst), .link(fpr_if_i), .req(req),
		.txLen(txLen), .txWord(txWord), .rxEn(rxEn), .wpAssert(wpAssert), .busy(hBusy),
		.done(hDone), .rxByte(rxByte));
	fpr_chk fpr_chk_i (.ref_clk(ref_clk), .rst(rst), .csN(fpr_if_i.csN), .wpN(fpr_if_i.wpN),
		.cmdValid(cmdValid), .resumeProg(resumeProg), .resumeErase(resumeErase),
		.protectOn(protectOn), .protRegLocked(protRegLocked), .busy(dBusy));

	always #5 ref_clk = ~ref_clk;

	always @(posedge ref_clk)
	begin
		nSusp += int'(suspendReq === 1'h1);
		nRp += int'(resumeProg === 1'h1);
		nRe += int'(resumeErase === 1'h1);
	end

	// ------------------------------------------------
	// helpers
	// ------------------------------------------------
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", samplesChecked, errTotal);
		if (errTotal == 0 && samplesChecked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask

	task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		samplesChecked++;
		if (seen !== exp)
		begin
			errTotal++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic wait_for(ref logic s, input logic v);
		int n;
		n = 0;
		while (s !== v && n < 3000)
		begin
			tick(1);
			n++;
		end
		if (n == 3000)
		begin
			errTotal++;
			wrap_up();
		end
	endtask

	task automatic frame(input logic [2:0] len, input logic [31:0] w, input logic rx);
		txLen = len;
		txWord = w;
		rxEn = rx;
		req = 1'h1;
		wait_for(hBusy, 1'h1);
		req = 1'h0;
		wait_for(hDone, 1'h1);
		wait_for(hBusy, 1'h0);
	endtask

	task automatic pulse(ref logic s);
		s = 1'h1;
		tick(1);
		s = 1'h0;
		tick(1);
		mBusy = 0;
	endtask

	function automatic logic allow(input logic [7:0] op);
		case (op)
			OPC_XFER_B1: return ps1 == 0;
			OPC_XFER_B2: return ps2 == 0;
			OPC_STATUS, OPC_CMP_B1, OPC_CMP_B2: return 1'h1;
			default: return (ps1 | ps2 | es) == 0;
		endcase
	endfunction

	task automatic chk_status();
		frame(3'h1, {OPC_STATUS, 24'h00_0000}, 1'h1);
		check("status", rxByte, {!mBusy, 1'(swEn | pinAct), 3'h0, 1'(es), 1'(ps2), 1'(ps1)});
	endtask

	task automatic table_chk();
		foreach (ops[i])
		begin
			frame(3'h4, {ops[i], 24'($urandom)}, 1'h0);
			check("cmdOp", cmdOp, ops[i]);
			check("cmdAllowed", 8'(cmdAllowed), 8'(allow(ops[i])));
		end
	endtask

	task automatic resume_chk();
		int rp;
		int re;
		int sp;
		rp = nRp;
		re = nRe;
		sp = nSusp;
		frame(3'h4, {OPC_RESUME, 24'($urandom)}, 1'h0);
		frame(3'h1, {OPC_SUSPEND, 24'h00_0000}, 1'h0);
		tick(int'(RESUME_CYC));
		check("suspend while resuming", 8'(nSusp), 8'(sp));
		if (ps1 != 0 || ps2 != 0)
			rp++;
		else
			re++;
		if (ps1 != 0)
			ps1 = 0;
		else if (ps2 != 0)
			ps2 = 0;
		else
			es = 0;
		mBusy = 1;
		check("resumeProg", 8'(nRp), 8'(rp));
		check("resumeErase", 8'(nRe), 8'(re));
		check("busy", 8'(dBusy), 8'(mBusy));
		chk_status();
		frame(3'h1, {OPC_SUSPEND, 24'h00_0000}, 1'h0);
		check("suspend after resume", 8'(nSusp), 8'(sp + 1));
		pulse(opDone);
	endtask

	task automatic chk_prot();
		tick(2);
		check("protectOn", 8'(protectOn), 8'(swEn | pinAct));
		check("protRegLocked", 8'(protRegLocked), 8'(pinAct));
	endtask

	task automatic prot(input logic [7:0] last, input logic [2:0] len);
		frame(len, {OPC_PROT_B0, OPC_PROT_B1, OPC_PROT_B2, last}, 1'h0);
		chk_prot();
	endtask

	task automatic pin(input logic a, input int n);
		wpAssert = a;
		tick(n);
		chk_prot();
	endtask

	// ------------------------------------------------
	// main sequence
	// ------------------------------------------------
	initial
	begin
		int s;
		s = $urandom(71771);
		// a real rising edge on rst, so serial-clock flops clear too
		#1;
		rst = 1'h1;
		tick(2);
		rst = 1'h0;
		tick(1);
		check("protectOn at reset", 8'(protectOn), 8'h00);
		chk_status();
		table_chk();
		pulse(b1Set);
		ps1 = 1;
		table_chk();
		resume_chk();
		pulse(b2Set);
		ps2 = 1;
		table_chk();
		resume_chk();
		pulse(eSet);
		es = 1;
		table_chk();
		pulse(b1Set);
		ps1 = 1;
		chk_status();
		prot(OPC_PROT_EN, 3'h4);
		resume_chk();
		resume_chk();
		prot(OPC_PROT_EN, 3'h3);
		prot(OPC_PROT_EN ^ 8'h01, 3'h4);
		swEn = 1;
		prot(OPC_PROT_EN, 3'h4);
		chk_status();
		swEn = 0;
		prot(OPC_PROT_DIS, 3'h4);
		pin(1'h1, 20);
		pin(1'h0, int'(ASSERT_CYC) + 20);
		pinAct = 1;
		pin(1'h1, int'(ASSERT_CYC) + 20);
		swEn = 1;
		prot(OPC_PROT_EN, 3'h4);
		prot(OPC_PROT_DIS, 3'h4);
		pin(1'h0, 20);
		pin(1'h1, int'(RELEASE_CYC) + 20);
		pinAct = 0;
		pin(1'h0, int'(RELEASE_CYC) + 20);
		swEn = 0;
		prot(OPC_PROT_DIS, 3'h4);
		pinAct = 1;
		pin(1'h1, int'(ASSERT_CYC) + 20);
		pinAct = 0;
		pin(1'h0, int'(RELEASE_CYC) + 20);
		swEn = 1;
		prot(OPC_PROT_EN, 3'h4);
		rst = 1'h1;
		tick(2);
		rst = 1'h0;
		swEn = 0;
		chk_prot();
		chk_status();
		wrap_up();
	end

	initial
	begin
		#800000;
		errTotal++;
		wrap_up();
	end
endmodule
